// File: core/scu_pkg.sv
// package for the serial unit: register offsets, field layout, reset values
// assumes one 100 MHz system clock and an 8-bit register port
package scu_pkg;
	localparam int CLK_HZ = 100_000_000;
	localparam int BAUD_DEFAULT = 115_200;
	localparam int OVERSAMPLE = 16;
	localparam int DIV_DEFAULT = CLK_HZ / (BAUD_DEFAULT * OVERSAMPLE);

	// register offsets
	localparam logic [3:0] OFS_TX_HOLD = 4'h0;
	localparam logic [3:0] OFS_RX_HOLD = 4'h1;
	localparam logic [3:0] OFS_STATUS = 4'h2;
	localparam logic [3:0] OFS_CTRL = 4'h3;
	localparam logic [3:0] OFS_DIV = 4'h4;
	localparam logic [3:0] OFS_IRQ_STAT = 4'h5;
	localparam logic [3:0] OFS_IRQ_MASK = 4'h6;

	// status bit positions
	localparam int ST_TXEMPTY = 0;
	localparam int ST_RXFULL = 1;
	localparam int ST_OVERRUN = 2;
	localparam int ST_FRAMING = 3;
	localparam int ST_PARITY = 4;
	localparam int ST_TXEND = 5;

	// control bit positions
	localparam int CT_TXEN = 0;
	localparam int CT_RXEN = 1;
	localparam int CT_PAREN = 2;
	localparam int CT_PARODD = 3;
	localparam int CT_RXIE = 4;

	// irq bit positions: 0 rx error, 1 rx full, 2 tx empty, 3 tx end
	localparam int IRQ_BITS = 4;

	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [3:0] TICK_MID = 4'h7;
	localparam logic [3:0] TICK_LAST = 4'hf;
	localparam logic [3:0] DATA_BITS = 4'h8;

	// register port bundle
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} scu_bus_t;

	typedef enum {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} scu_rx_state_t;
	typedef enum {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} scu_tx_state_t;
endpackage : scu_pkg

// File: core/scu_serial.sv
// asynchronous serial unit: holding registers, error flags, 16x sampling
// assumes rxLine is already synchronous to clk_sys and idles high
//
// Local design decisions: the address-and-strobe port and the register offsets.
`timescale 1ns/100ps

module scu_serial #(
	parameter int DIV_W = 16,
	parameter logic [15:0] DIV_RESET = 16'(scu_pkg::DIV_DEFAULT)
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire scu_pkg::scu_bus_t bus,
	output logic [7:0] rdata,
	input wire logic rxLine,
	output logic txLine,
	output logic rxErrIrq,
	output logic irq
);
	logic [7:0] txHold_r, txShift_r, rxHold_r, rxShift_r, ctrl_r;
	logic [DIV_W-1:0] div_r, divCnt_r;
	logic txEmpty_r, txEnd_r, rxFull_r, ovr_r, frm_r, par_r;
	localparam int IRQ_BITS_W = scu_pkg::IRQ_BITS;
	logic [IRQ_BITS_W-1:0] irqStat_r, irqMask_r;
	logic rxPrev_r, rxParBit_r, txParBit_r;
	logic [3:0] rxTick_r, rxBit_r, txTick_r, txBit_r;
	scu_pkg::scu_rx_state_t rxSt_r;
	scu_pkg::scu_tx_state_t txSt_r;

	// decode of the register port
	wire logic wrTx = bus.wr && bus.addr == scu_pkg::OFS_TX_HOLD;
	wire logic wrSt = bus.wr && bus.addr == scu_pkg::OFS_STATUS;
	wire logic wrCt = bus.wr && bus.addr == scu_pkg::OFS_CTRL;
	wire logic wrDv = bus.wr && bus.addr == scu_pkg::OFS_DIV;
	wire logic wrIs = bus.wr && bus.addr == scu_pkg::OFS_IRQ_STAT;
	wire logic wrIm = bus.wr && bus.addr == scu_pkg::OFS_IRQ_MASK;
	wire logic anyErr = ovr_r | frm_r | par_r;
	wire logic rxRun = ctrl_r[scu_pkg::CT_RXEN] && !anyErr;
	wire logic txRun = ctrl_r[scu_pkg::CT_TXEN] && !anyErr;

	// 16x sample tick from the divider; one tick per sixteenth bit
	wire logic tick = divCnt_r == '0;
	always_ff @(posedge clk_sys) begin
		if (reset || tick) begin
			divCnt_r <= reset ? '0 : div_r;
		end else begin
			divCnt_r <= divCnt_r - 1'b1;
		end
	end

	// falling line edge seen on a tick; stands for the start bit's leading edge
	wire logic startEdge = tick && rxPrev_r && !rxLine;
	wire logic midTick = tick && rxTick_r == scu_pkg::TICK_MID;
	wire logic frameDone = midTick && rxSt_r == scu_pkg::RX_STOP;
	wire logic stopBad = !rxLine;
	wire logic parBad = ctrl_r[scu_pkg::CT_PAREN] &&
		(rxParBit_r != (^rxShift_r ^ ctrl_r[scu_pkg::CT_PARODD]));
	wire logic ovrNow = frameDone && rxFull_r;
	wire logic rxClr = wrSt && !bus.wdata[scu_pkg::ST_RXFULL];
	// a set in the same cycle as a clear wins
	wire logic rxFullSet = frameDone && !rxFull_r && !stopBad && !parBad;

	// receiver sequencer; starts no new frame while an error flag is set
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			rxSt_r <= scu_pkg::RX_IDLE;
			rxTick_r <= 4'h0;
			rxBit_r <= 4'h0;
			rxShift_r <= 8'h00;
			rxParBit_r <= 1'b0;
			rxPrev_r <= 1'b1;
		end else if (tick) begin
			// held high while stopped, so a line still low in a break
			// starts a new frame as soon as the error flags are cleared
			rxPrev_r <= rxLine || !rxRun;
			rxTick_r <= rxTick_r + 4'h1;
			case (rxSt_r)
				scu_pkg::RX_IDLE: begin
					rxTick_r <= 4'h0;
					if (startEdge && rxRun) begin
						rxSt_r <= scu_pkg::RX_START;
					end
				end
				scu_pkg::RX_START: begin
					if (midTick) begin
						rxTick_r <= 4'h8; // realign: next centre is 16 ticks on
						rxBit_r <= 4'h0;
						rxSt_r <= rxLine ? scu_pkg::RX_IDLE : scu_pkg::RX_DATA;
					end
				end
				scu_pkg::RX_DATA: begin
					if (midTick) begin
						rxShift_r <= {rxLine, rxShift_r[7:1]};
						rxBit_r <= rxBit_r + 4'h1;
						if (rxBit_r == scu_pkg::DATA_BITS - 4'h1) begin
							rxSt_r <= ctrl_r[scu_pkg::CT_PAREN] ?
								scu_pkg::RX_PAR : scu_pkg::RX_STOP;
						end
					end
				end
				scu_pkg::RX_PAR: begin
					if (midTick) begin
						rxParBit_r <= rxLine;
						rxSt_r <= scu_pkg::RX_STOP;
					end
				end
				default: begin
					if (midTick) begin
						rxSt_r <= scu_pkg::RX_IDLE;
					end
				end
			endcase
		end
	end

	// receive flags and holding register
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			rxHold_r <= scu_pkg::BYTE_ZERO;
			rxFull_r <= 1'b0;
			ovr_r <= 1'b0;
			frm_r <= 1'b0;
			par_r <= 1'b0;
		end else begin
			if (frameDone && !rxFull_r) begin
				rxHold_r <= rxShift_r;
			end
			rxFull_r <= rxFullSet || (rxFull_r && !rxClr);
			ovr_r <= ovrNow || (ovr_r && !(wrSt &&
				!bus.wdata[scu_pkg::ST_OVERRUN]));
			frm_r <= (frameDone && stopBad) || (frm_r && !(wrSt &&
				!bus.wdata[scu_pkg::ST_FRAMING]));
			par_r <= (frameDone && parBad) || (par_r && !(wrSt &&
				!bus.wdata[scu_pkg::ST_PARITY]));
		end
	end

	// transmitter; holding register takes every write
	wire logic txTick = tick && txTick_r == scu_pkg::TICK_LAST;
	wire logic txLoad = txRun && !txEmpty_r &&
		(txSt_r == scu_pkg::TX_IDLE || (txTick && txSt_r == scu_pkg::TX_STOP));
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			txHold_r <= scu_pkg::BYTE_ZERO;
			txEmpty_r <= 1'b1;
			txEnd_r <= 1'b1;
		end else begin
			if (wrTx) begin
				txHold_r <= bus.wdata;
			end
			txEmpty_r <= txLoad || (txEmpty_r && !wrTx);
			txEnd_r <= (txTick && txSt_r == scu_pkg::TX_STOP && txEmpty_r) ||
				(txEnd_r && !txLoad);
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			txSt_r <= scu_pkg::TX_IDLE;
			txShift_r <= 8'h00;
			txTick_r <= 4'h0;
			txBit_r <= 4'h0;
			txParBit_r <= 1'b0;
			txLine <= 1'b1;
		end else if (txLoad) begin
			txShift_r <= txHold_r;
			txParBit_r <= ^txHold_r ^ ctrl_r[scu_pkg::CT_PARODD];
			txSt_r <= scu_pkg::TX_START;
			txTick_r <= 4'h0;
			txBit_r <= 4'h0;
			txLine <= 1'b0;
		end else if (tick && txSt_r != scu_pkg::TX_IDLE && txRun) begin
			txTick_r <= txTick_r + 4'h1;
			if (txTick) begin
				case (txSt_r)
					scu_pkg::TX_START: begin
						txSt_r <= scu_pkg::TX_DATA;
						txLine <= txShift_r[0];
					end
					scu_pkg::TX_DATA: begin
						txBit_r <= txBit_r + 4'h1;
						txShift_r <= {1'b0, txShift_r[7:1]};
						if (txBit_r == scu_pkg::DATA_BITS - 4'h1) begin
							txSt_r <= ctrl_r[scu_pkg::CT_PAREN] ?
								scu_pkg::TX_PAR : scu_pkg::TX_STOP;
							txLine <= ctrl_r[scu_pkg::CT_PAREN] ?
								txParBit_r : 1'b1;
						end else begin
							txLine <= txShift_r[1];
						end
					end
					scu_pkg::TX_PAR: begin
						txSt_r <= scu_pkg::TX_STOP;
						txLine <= 1'b1;
					end
					default: begin
						txSt_r <= scu_pkg::TX_IDLE;
						txLine <= 1'b1;
					end
				endcase
			end
		end
	end

	// control, divider, interrupt status (write one to clear) and mask
	wire logic [IRQ_BITS_W-1:0] irqEv = {txEnd_r, txEmpty_r,
		rxFullSet, frameDone && (stopBad || parBad || rxFull_r)};
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			ctrl_r <= scu_pkg::CTRL_RESET;
			div_r <= DIV_RESET[DIV_W-1:0];
			irqStat_r <= '0;
			irqMask_r <= '0;
		end else begin
			if (wrCt) begin
				ctrl_r <= bus.wdata;
			end
			if (wrDv) begin
				div_r <= DIV_W'(bus.wdata);
			end
			if (wrIm) begin
				irqMask_r <= bus.wdata[IRQ_BITS_W-1:0];
			end
			irqStat_r <= irqEv | (irqStat_r &
				~(wrIs ? bus.wdata[IRQ_BITS_W-1:0] : '0));
		end
	end

	// level outputs; error request follows the flags themselves
	assign rxErrIrq = anyErr && ctrl_r[scu_pkg::CT_RXIE];
	assign irq = |(irqStat_r & irqMask_r);

	// read data valid in the cycle after the read strobe; unmapped reads 0
	wire logic [7:0] status = {2'b00, txEnd_r, par_r, frm_r, ovr_r,
		rxFull_r, txEmpty_r};
	wire logic [7:0] rdMux =
		bus.addr == scu_pkg::OFS_TX_HOLD ? txHold_r :
		bus.addr == scu_pkg::OFS_RX_HOLD ? rxHold_r :
		bus.addr == scu_pkg::OFS_STATUS ? status :
		bus.addr == scu_pkg::OFS_CTRL ? ctrl_r :
		bus.addr == scu_pkg::OFS_DIV ? 8'(div_r) :
		bus.addr == scu_pkg::OFS_IRQ_STAT ? 8'(irqStat_r) :
		bus.addr == scu_pkg::OFS_IRQ_MASK ? 8'(irqMask_r) : 8'h00;
	always_ff @(posedge clk_sys) begin
		if (reset || !bus.rd) begin
			rdata <= 8'h00;
		end else begin
			rdata <= rdMux;
		end
	end
endmodule : scu_serial

// File: tb/scu_line_src.sv
// remote transmitter on the receive line, data lsb first
// assumes the unit counts BIT clocks per bit
`timescale 1ns/100ps
module scu_line_src #(
	parameter int BIT = 16
) (
	input wire logic clk_sys,
	output logic rxLine
);
	initial rxLine = 1'b1; // idle high between frames
	// start, data, parity if pe, stop; stp 0 makes a bad stop
	task automatic frame(input logic [7:0] d, input logic p,
		input logic pe, input logic stp);
		logic [10:0] f;
		f = {stp, p, d, 1'b0};
		for (int k = 0; k < 11; k++) begin
			if (k != 9 || pe) begin
				@(posedge clk_sys);
				rxLine <= f[k];
				repeat (BIT - 1) @(posedge clk_sys);
			end
		end
		@(posedge clk_sys);
		rxLine <= 1'b1;
	endtask : frame
	// hold the line at a level, low for a break
	task automatic hold(input logic lvl);
		@(posedge clk_sys);
		rxLine <= lvl;
	endtask : hold
endmodule : scu_line_src

// File: tb/scu_serial_sva.sv
// checker of port relations for the serial unit
// assumes it is bound into scu_serial and sees its ports only
`timescale 1ns/100ps
module scu_serial_sva (
	input wire logic clk_sys,
	input wire logic reset,
	input wire scu_pkg::scu_bus_t bus,
	input wire logic [7:0] rdata,
	input wire logic rxLine,
	input wire logic txLine,
	input wire logic rxErrIrq,
	input wire logic irq
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);
	// write then read back of one register, no gap
	sequence s_ctrl;
		bus.wr && bus.addr == 4'h3 ##1 bus.rd && bus.addr == 4'h3;
	endsequence
	sequence s_clr;
		bus.wr && bus.addr == 4'h2 && bus.wdata[4:2] == 3'h0
		##1 bus.rd && bus.addr == 4'h2;
	endsequence
	property p_idle; !bus.rd |=> rdata == 8'h00; endproperty
	property p_unmap; bus.rd && bus.addr > 4'h6 |=> rdata == 8'h00; endproperty
	property p_ctrl; s_ctrl |=> rdata[4:0] == $past(bus.wdata[4:0], 2);
	endproperty
	property p_clr; s_clr |=> rdata[4:2] == 3'h0; endproperty
	property p_err; rxErrIrq && bus.rd && bus.addr == 4'h2 |=> |rdata[4:2];
	endproperty
	// sticky flags leave only through a register write; tx line holds while the error request stays up
	property p_errHold; $fell(rxErrIrq) |-> $past(bus.wr) || $past(bus.wr, 2);
	endproperty
	property p_irqHold; $fell(irq) |-> $past(bus.wr) || $past(bus.wr, 2);
	endproperty
	property p_freeze; rxErrIrq [*2] |-> $stable(txLine); endproperty
	a_idle: assert property (p_idle) else $error("rdata not idle");
	a_unmap: assert property (p_unmap) else $error("unmapped read");
	a_ctrl: assert property (p_ctrl) else $error("ctrl readback");
	a_clr: assert property (p_clr)
		else $error("error flag not cleared");
	a_err: assert property (p_err)
		else $error("error irq without flag");
	a_errHold: assert property (p_errHold)
		else $error("error irq dropped");
	a_irqHold: assert property (p_irqHold) else $error("irq dropped");
	a_freeze: assert property (p_freeze)
		else $error("tx moved during error");
endmodule : scu_serial_sva
bind scu_serial scu_serial_sva u_sva (.clk_sys, .reset, .bus, .rdata,
	.rxLine, .txLine, .rxErrIrq, .irq);

// File: tb/scu_serial_tb.sv
// self-checking bench: register port tasks, line model, tx capture
// assumes div 0, so one bit is sixteen clocks
`timescale 1ns/100ps
module scu_serial_tb;
	localparam int BIT = 16;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	scu_pkg::scu_bus_t bus = '0;
	logic [7:0] rdata, got, d;
	logic rxLine, txLine, rxErrIrq, irq;
	int mismatches = 0, checks_done = 0, n;
	scu_serial DUT (.clk_sys(clk_sys), .reset(reset), .bus(bus),
		.rdata(rdata), .rxLine(rxLine), .txLine(txLine),
		.rxErrIrq(rxErrIrq), .irq(irq));
	scu_line_src #(.BIT(BIT)) SRC (.clk_sys(clk_sys), .rxLine(rxLine));
	initial begin
		forever #5 clk_sys = ~clk_sys;
	end
	task automatic check(input string s, input logic [7:0] e,
		input logic [7:0] g);
		checks_done++;
		if (g !== e) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", s, e, g);
		end
	endtask : check
	// strobe left up; the next call or idle replaces it
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge clk_sys);
		bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
	endtask : wr
	task automatic idle(input int c);
		@(posedge clk_sys);
		bus <= '0;
		repeat (c) @(posedge clk_sys);
	endtask : idle
	// data taken in the one cycle after the strobe, once settled
	task automatic rdChk(input logic [3:0] a, input logic [7:0] e);
		@(posedge clk_sys);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk_sys);
		bus <= '0;
		#1;
		check("register", e, rdata);
	endtask : rdChk
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : end_of_test
	// watchdog: the run needs about 3000 clocks
	initial begin
		#500_000;
		mismatches++;
		end_of_test();
	end
	initial begin
		repeat (20) @(posedge clk_sys);
		reset <= 1'b0;
		rdChk(4'h2, 8'h21);
		rdChk(4'hf, 8'h00);
		wr(4'h4, 8'h00);
		// divider takes the new value only at its next reload
		idle(BIT * 4);
		wr(4'h3, 8'h13);
		rdChk(4'h3, 8'h13);
		rdChk(4'h2, 8'h21);
		// second byte replaced while the first is on the line
		wr(4'h0, 8'h81);
		idle(BIT * 3);
		wr(4'h0, 8'h4e);
		wr(4'h0, 8'hc3);
		idle(BIT * 6 + 8);
		for (n = 0; txLine !== 1'b0 && n < 500; n++) @(posedge clk_sys);
		repeat (7) @(posedge clk_sys);
		for (int k = 0; k < 8; k++) begin
			repeat (BIT) @(posedge clk_sys);
			got[k] = txLine;
		end
		check("tx byte", 8'hc3, got);
		$display("test tx done");
		// let the last stop bit finish so tx end is set again
		idle(BIT * 2);
		// every mix of overrun, framing and parity errors
		wr(4'h3, 8'h17);
		for (int i = 1; i < 8; i++) begin
			d = 8'h60 + 8'(i);
			wr(4'h2, 8'h00);
			rdChk(4'h2, 8'h21);
			if (i[2]) SRC.frame(8'h11, 1'b0, 1'b1, 1'b1);
			SRC.frame(d, ^d ^ i[1], 1'b1, !i[0]);
			rdChk(4'h2, {3'h1, i[1], i[0], i[2], i[2], 1'b1});
			rdChk(4'h1, i[2] ? 8'h11 : d);
			check("err irq", 8'h01, {7'h0, rxErrIrq});
		end
		// errors held: a good frame is not taken
		wr(4'h2, 8'h1c);
		idle(0);
		SRC.frame(8'h99, 1'b0, 1'b1, 1'b1);
		rdChk(4'h2, 8'h3d);
		rdChk(4'h1, 8'h11);
		wr(4'h3, 8'h03);
		idle(2);
		check("err irq", 8'h00, {7'h0, rxErrIrq});
		check("irq", 8'h00, {7'h0, irq});
		wr(4'h6, 8'h01);
		idle(2);
		check("irq", 8'h01, {7'h0, irq});
		wr(4'h5, 8'h01);
		idle(2);
		check("irq", 8'h00, {7'h0, irq});
		$display("test rx errors done");
		// line break, then again once the flag is cleared
		wr(4'h2, 8'h00);
		idle(0);
		SRC.hold(1'b0);
		for (int j = 0; j < 2; j++) begin
			idle(BIT * 12);
			rdChk(4'h2, 8'h29);
			rdChk(4'h1, 8'h00);
			wr(4'h2, 8'h00);
		end
		idle(0);
		SRC.hold(1'b1);
		$display("test break done");
		end_of_test();
	end
endmodule : scu_serial_tb
